/* File: hw/rfg_core.sv */
// Decided for this implementation: the register offsets and the Wishbone register port.
`timescale 1ns/1ps
// Overview of operation
// - Zero rounding: 0 to full scale takes exactly the rise time; same slope for smaller.
// - Zero rounding: full scale to 0 takes exactly the fall time; same slope.
// - Toward zero uses fall timing, away from zero uses rise timing.
// - Mode 0: reversal aborts ramp, opposite initial rounding starts at once.
// - Mode 1: reversal blends smoothly, overshooting in the old direction.
// - Generator enable low forces output to zero.
// - Start high feeds setpoint; low feeds output back, holding it.
// - Setpoint enable low selects setting 1 and ramps to zero.
// - Set-output high loads the output with the selected set value.
// - Bypass gives zero rise and fall time; output follows input.
// - Selector inputs pick setting 1, 2 or 3, each with four times.
// - Both selectors high raise the setting-conflict fault.
// - Selector choice of setting 2 or 3 beats the integrator choice.
// - Integrator active for mode 1, 2 or 3; mode names target setting.
// - After switch-on, integrator uses setting 1 until setpoint first reached.
// - Switch enable high at first reach switches to the mode's setting.
// - Switch enable low at reach keeps setting 1 until it rises.
// - Switch enable falling returns to setting 1 and clears the reach; rising switches once a reach follows the fall.
// - Switch-off returns the integrator to setting 1 and clears the reach; the output keeps following its input.
module rfg_core
	import rfg_pkg::*;
#(
	parameter int CYC_PER_MS = RFG_CYC_PER_MS
) (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic      [15:0] ramp_out,
	output logic             setting_conflict_fault
);

	// ----------------------------------------------------------------
	// Parameter check
	// ----------------------------------------------------------------
	// Below full-scale codes per millisecond the output would need
	// more than one code step per clock and the timing would sag.
	if (CYC_PER_MS < int'(RFG_FULL_SCALE)) begin : g_bad_cyc
		$error("CYC_PER_MS must be at least the full-scale code count");
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] lane_merge(
		input logic [15:0] old_v,
		input logic [31:0] wd,
		input logic [3:0]  sel
	);
		lane_merge = old_v;
		if (sel[0]) begin
			lane_merge[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			lane_merge[15:8] = wd[15:8];
		end
	endfunction

	function automatic logic signed [15:0] clip_fs(input logic signed [15:0] v);
		if (v > RFG_FULL_SCALE) begin
			clip_fs = RFG_FULL_SCALE;
		end else if (v < RFG_NEG_SCALE) begin
			clip_fs = RFG_NEG_SCALE;
		end else begin
			clip_fs = v;
		end
	endfunction

	function automatic logic [15:0] time_of(
		input logic [11:0][15:0] tm,
		input logic [1:0]        setting,
		input logic [1:0]        kind
	);
		time_of = tm[{setting, kind}];
	endfunction

	// Cycle threshold for one code step at full slope
	function automatic logic [47:0] step_limit(input logic [15:0] t_ms);
		step_limit = 48'(t_ms) * 48'(CYC_PER_MS) * 48'(RFG_SLOPE_MAX);
	endfunction

	rfg_state_t q;
	rfg_state_t d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic               hit;
		logic               wr;
		logic [5:0]         widx;
		logic [3:0]         tidx;
		logic               sw_on;
		logic               sel2;
		logic               sel3;
		logic               conflict;
		logic               on_edge;
		logic               en_fall;
		logic [1:0]         imode;
		logic               int_use;
		logic [1:0]         setting;
		logic signed [15:0] tgt;
		logic signed [16:0] err;
		logic [16:0]        abs_err;
		logic               want_up;
		logic               mv_up;
		logic               away;
		logic [15:0]        t_ramp;
		logic [15:0]        t_init;
		logic [15:0]        t_fin;
		logic [15:0]        t_round;
		logic               reversal;
		logic               brake;
		logic [47:0]        lim;
		logic [47:0]        rlim;
		logic [47:0]        acc_n;
		logic [47:0]        sacc_n;
		logic [31:0]        stat;

		d        = q;
		hit      = wb_cyc_i & wb_stb_i & ~q.ack;
		wr       = hit & wb_we_i;
		widx     = wb_adr_i[7:2];
		tidx     = 4'(widx - RFG_TIME_OFS[7:2]);
		sw_on    = q.ctrl[RFG_C_SWITCH_ON];
		sel2     = q.ctrl[RFG_C_SET2_SEL];
		sel3     = q.ctrl[RFG_C_SET3_SEL];
		imode    = q.ctrl[RFG_C_INT_MODE +: 2];
		conflict = sel2 & sel3;
		on_edge  = sw_on & ~q.sw_on_prev;
		en_fall  = ~q.ctrl[RFG_C_INT_SW_EN] & q.sw_en_prev;
		reversal = 1'b0;
		brake    = 1'b0;
		acc_n    = '0;
		sacc_n   = '0;
		t_round  = '0;
		int_use  = 1'b0;
		setting  = '0;
		tgt      = '0;
		err      = '0;
		abs_err  = '0;
		want_up  = 1'b0;
		mv_up    = 1'b0;
		away     = 1'b0;
		t_ramp   = '0;
		t_init   = '0;
		t_fin    = '0;
		lim      = '0;
		rlim     = '0;
		stat     = '0;

		// Generator input
		if (!q.ctrl[RFG_C_SP_EN]) begin
			tgt = '0;
		end else if (q.ctrl[RFG_C_START]) begin
			tgt = clip_fs(q.sp);
		end else begin
			tgt = q.out;
		end

		// ------------------------------------------------------------
		// Integrator bookkeeping
		// ------------------------------------------------------------
		d.sw_on_prev = sw_on;
		d.sw_en_prev = q.ctrl[RFG_C_INT_SW_EN];
		// A new switch-on must see a fresh reach, so its clear wins
		if (on_edge || en_fall || !sw_on) begin
			d.reached = 1'b0;
		end else if (q.out == tgt) begin
			d.reached = 1'b1;
		end
		int_use = (imode != 2'h0) & q.reached & q.ctrl[RFG_C_INT_SW_EN] & sw_on;

		// ------------------------------------------------------------
		// Setting selection
		// ------------------------------------------------------------
		if (!q.ctrl[RFG_C_SP_EN] || conflict) begin
			setting = 2'h0;
		end else if (sel2) begin
			setting = 2'h1;
		end else if (sel3) begin
			setting = 2'h2;
		end else if (int_use) begin
			setting = 2'(imode - 2'h1);
		end else begin
			setting = 2'h0;
		end
		// Set wins over a clear in the same cycle
		d.fault = q.fault | conflict;
		if (wr && widx == RFG_FAULT_OFS[7:2] && wb_sel_i[0] && wb_dat_i[0]) begin
			d.fault = conflict;
		end

		t_init = time_of(q.tm, setting, RFG_T_INIT);
		t_fin  = time_of(q.tm, setting, RFG_T_FIN);

		// ------------------------------------------------------------
		// Ramp engine
		// ------------------------------------------------------------
		err     = 17'(tgt) - 17'(q.out);
		abs_err = err[16] ? 17'(-err) : err;
		want_up = ~err[16];
		mv_up   = (q.slope == '0) ? want_up : q.dir_up;
		away    = (q.out == '0) | (mv_up ? ~q.out[15] : q.out[15]);
		t_ramp  = away ? time_of(q.tm, setting, RFG_T_RISE)
			: time_of(q.tm, setting, RFG_T_FALL);
		lim     = step_limit(t_ramp);

		if (!q.ctrl[RFG_C_GEN_EN]) begin
			d.out   = '0;
			d.slope = '0;
			d.acc   = '0;
			d.sacc  = '0;
			d.ph    = RFG_HOLD;
		end else if (q.ctrl[RFG_C_SET_OUT]) begin
			d.out   = q.ctrl[RFG_C_SET_SEL] ? clip_fs(q.sp) : clip_fs(q.setv);
			d.slope = '0;
			d.acc   = '0;
			d.sacc  = '0;
			d.ph    = RFG_HOLD;
		end else if (q.ctrl[RFG_C_BYPASS] || t_ramp == '0) begin
			d.out   = tgt;
			d.slope = '0;
			d.acc   = '0;
			d.sacc  = '0;
			d.ph    = RFG_HOLD;
		end else if (err == '0) begin
			// Arrival drops the residual slope in one step
			d.slope = '0;
			d.acc   = '0;
			d.sacc  = '0;
			d.ph    = RFG_HOLD;
		end else begin
			if (q.slope == '0 && q.ph != RFG_DECEL) begin
				d.dir_up = want_up;
				d.ph     = RFG_ACCEL;
			end else if (want_up != q.dir_up) begin
				reversal = 1'b1;
				if (!q.ctrl[RFG_C_REV_MODE]) begin
					d.dir_up = want_up;
					d.ph     = RFG_ACCEL;
				end else begin
					d.ph = RFG_DECEL;
				end
			end else begin
				brake = (48'(abs_err) * 48'(t_ramp) << (RFG_SLOPE_SHIFT + 1))
					<= (48'(RFG_FULL_SCALE) * 48'(q.slope) * 48'(t_fin));
				if (brake && q.slope != '0) begin
					d.ph = RFG_DECEL;
				end else if (q.slope < RFG_SLOPE_MAX) begin
					d.ph = RFG_ACCEL;
				end else begin
					d.ph = RFG_CRUISE;
				end
			end

			// Slope follows the rounding time linearly
			t_round = (d.ph == RFG_ACCEL) ? t_init : t_fin;
			rlim    = 48'(t_round) * 48'(CYC_PER_MS);
			sacc_n  = q.sacc + 48'(RFG_SLOPE_MAX);
			if (reversal && !q.ctrl[RFG_C_REV_MODE]) begin
				d.slope = '0;
				d.sacc  = '0;
			end else begin
				unique case (d.ph)
					RFG_ACCEL: begin
						if (t_round == '0) begin
							d.slope = RFG_SLOPE_MAX;
						end else if (sacc_n >= rlim) begin
							d.slope = q.slope + 9'h001;
							sacc_n  = sacc_n - rlim;
						end
					end
					RFG_DECEL: begin
						if (t_round == '0) begin
							d.slope = reversal ? 9'h000 : q.slope;
						end else if (sacc_n >= rlim) begin
							sacc_n = sacc_n - rlim;
							// Keep creeping toward the target, stop on reversal
							if (reversal || q.slope > 9'h001) begin
								d.slope = q.slope - 9'h001;
							end
						end
						if (reversal && d.slope == '0) begin
							d.ph = RFG_HOLD;
						end
					end
					RFG_CRUISE: begin
						d.slope = RFG_SLOPE_MAX;
						sacc_n  = '0;
					end
					RFG_HOLD: begin
						d.slope = '0;
						sacc_n  = '0;
					end
				endcase
				d.sacc = sacc_n;
			end

			// Code-step accumulator: full scale per ramp time at full slope
			acc_n = q.acc + 48'(RFG_FULL_SCALE) * 48'(q.slope);
			if (acc_n >= lim) begin
				acc_n = acc_n - lim;
				d.out = q.dir_up ? q.out + 16'sh0001 : q.out - 16'sh0001;
			end
			d.acc = (reversal && !q.ctrl[RFG_C_REV_MODE]) ? '0 : acc_n;
		end

		// ------------------------------------------------------------
		// Register bus
		// ------------------------------------------------------------
		stat = '0;
		stat[RFG_S_AT_SP]        = (q.out == tgt);
		stat[RFG_S_REACHED]      = q.reached;
		stat[RFG_S_INT_USE]      = int_use;
		stat[RFG_S_SETTING +: 2] = setting;
		stat[RFG_S_CONFLICT]     = conflict;
		stat[RFG_S_PHASE +: 2]   = q.ph;

		d.ack = hit;
		if (hit) begin
			d.rdat = '0;
			if (widx == RFG_CTRL_OFS[7:2]) begin
				d.rdat[15:0] = q.ctrl;
			end else if (widx == RFG_SP_OFS[7:2]) begin
				d.rdat[15:0] = q.sp;
			end else if (widx == RFG_SETV_OFS[7:2]) begin
				d.rdat[15:0] = q.setv;
			end else if (widx == RFG_STAT_OFS[7:2]) begin
				d.rdat = stat;
			end else if (widx == RFG_OUT_OFS[7:2]) begin
				d.rdat = 32'(q.out);
			end else if (widx == RFG_FAULT_OFS[7:2]) begin
				d.rdat[0] = q.fault;
			end else if (wb_adr_i >= RFG_TIME_OFS && wb_adr_i <= RFG_TIME_LAST) begin
				d.rdat[15:0] = q.tm[tidx];
			end
		end
		if (wr) begin
			if (widx == RFG_CTRL_OFS[7:2]) begin
				d.ctrl = lane_merge(q.ctrl, wb_dat_i, wb_sel_i);
			end else if (widx == RFG_SP_OFS[7:2]) begin
				d.sp = lane_merge(q.sp, wb_dat_i, wb_sel_i);
			end else if (widx == RFG_SETV_OFS[7:2]) begin
				d.setv = lane_merge(q.setv, wb_dat_i, wb_sel_i);
			end else if (wb_adr_i >= RFG_TIME_OFS && wb_adr_i <= RFG_TIME_LAST) begin
				d.tm[tidx] = lane_merge(q.tm[tidx], wb_dat_i, wb_sel_i);
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			q       <= '0;
			q.ctrl  <= RFG_CTRL_RST;
			q.ph    <= RFG_HOLD;
			for (int i = 0; i < RFG_NUM_TIMES; i++) begin
				q.tm[i] <= (2'(i) == RFG_T_RISE || 2'(i) == RFG_T_FALL)
					? RFG_RAMP_RST : RFG_ROUND_RST;
			end
		end else begin
			q <= d;
		end
	end

	assign wb_ack_o               = q.ack;
	assign wb_dat_o               = q.rdat;
	assign ramp_out               = q.out;
	assign setting_conflict_fault = q.fault;

endmodule // rfg_core

/* File: inc/rfg_pkg.sv */
package rfg_pkg;

	// ----------------------------------------------------------------
	// Scaling and timing
	// ----------------------------------------------------------------
	// Signed output codes; this value is 100 % of full scale
	localparam logic signed [15:0] RFG_FULL_SCALE  = 16'sh4000;
	localparam logic signed [15:0] RFG_NEG_SCALE   = -16'sh4000;
	// Slope resolution: slope runs from zero up to this level
	localparam logic [8:0]         RFG_SLOPE_MAX   = 9'h100;
	localparam int                 RFG_SLOPE_SHIFT = 8;
	// One millisecond at the 100 MHz system clock
	localparam int                 RFG_CLK_MHZ     = 100;
	localparam int                 RFG_MS_US       = 1000;
	localparam int                 RFG_CYC_PER_MS  = RFG_CLK_MHZ * RFG_MS_US;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] RFG_CTRL_OFS   = 8'h00;
	localparam logic [7:0] RFG_SP_OFS     = 8'h04;
	localparam logic [7:0] RFG_SETV_OFS   = 8'h08;
	localparam logic [7:0] RFG_STAT_OFS   = 8'h0C;
	localparam logic [7:0] RFG_OUT_OFS    = 8'h10;
	localparam logic [7:0] RFG_FAULT_OFS  = 8'h14;
	localparam logic [7:0] RFG_TIME_OFS   = 8'h20;
	localparam logic [7:0] RFG_TIME_LAST  = 8'h4C;
	localparam int         RFG_NUM_TIMES  = 12;

	// Index of each time within one setting
	localparam logic [1:0] RFG_T_RISE = 2'h0;
	localparam logic [1:0] RFG_T_FALL = 2'h1;
	localparam logic [1:0] RFG_T_INIT = 2'h2;
	localparam logic [1:0] RFG_T_FIN  = 2'h3;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int RFG_C_SWITCH_ON  = 0;
	localparam int RFG_C_SET2_SEL   = 1;
	localparam int RFG_C_SET3_SEL   = 2;
	localparam int RFG_C_BYPASS     = 3;
	localparam int RFG_C_GEN_EN     = 4;
	localparam int RFG_C_START      = 5;
	localparam int RFG_C_SP_EN      = 6;
	localparam int RFG_C_SET_OUT    = 7;
	localparam int RFG_C_SET_SEL    = 8;
	localparam int RFG_C_INT_SW_EN  = 9;
	localparam int RFG_C_REV_MODE   = 10;
	localparam int RFG_C_INT_MODE   = 12;

	// Status register fields
	localparam int RFG_S_AT_SP      = 0;
	localparam int RFG_S_REACHED    = 1;
	localparam int RFG_S_INT_USE    = 2;
	localparam int RFG_S_SETTING    = 3;
	localparam int RFG_S_CONFLICT   = 5;
	localparam int RFG_S_PHASE      = 6;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RFG_CTRL_RST  = 16'h0000;
	localparam logic [15:0] RFG_RAMP_RST  = 16'h000A;
	localparam logic [15:0] RFG_ROUND_RST = 16'h0000;

	// Ramp phase, Gray coded along hold, accelerate, cruise, decelerate
	typedef enum logic [1:0] {
		RFG_HOLD   = 2'b00,
		RFG_ACCEL  = 2'b01,
		RFG_CRUISE = 2'b11,
		RFG_DECEL  = 2'b10
	} rfg_phase_t;

	typedef struct packed {
		logic                 ack;
		logic [31:0]          rdat;
		logic [15:0]          ctrl;
		logic signed [15:0]   sp;
		logic signed [15:0]   setv;
		logic [11:0][15:0]    tm;
		logic                 fault;
		logic signed [15:0]   out;
		logic                 dir_up;
		logic [8:0]           slope;
		logic [47:0]          acc;
		logic [47:0]          sacc;
		rfg_phase_t           ph;
		logic                 sw_on_prev;
		logic                 sw_en_prev;
		logic                 reached;
	} rfg_state_t;

endpackage

/* File: dv/rfg_core_properties.sv */
`timescale 1ns/1ps
module rfg_core_properties
	import rfg_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic [15:0] ramp_out,
	input wire logic        setting_conflict_fault
);
	// ----------------------------------------------------------------
	// Shadow of the written controls, committed at the ack edge
	// ----------------------------------------------------------------
	logic        [15:0] ctl_q;
	logic signed [15:0] sp_q;
	logic signed [15:0] setv_q;
	logic               wr_ack;
	assign wr_ack = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ctl_q <= RFG_CTRL_RST;
			sp_q <= 16'sh0000;
			setv_q <= 16'sh0000;
		end else if (wr_ack) begin
			case (wb_adr_i)
				RFG_CTRL_OFS: ctl_q <= wb_dat_i[15:0];
				RFG_SP_OFS: sp_q <= wb_dat_i[15:0];
				RFG_SETV_OFS: setv_q <= wb_dat_i[15:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	// Windows of several cycles absorb the one or two cycles of control latency
	sequence s_ramp;
		(ctl_q[4] && !ctl_q[3] && !ctl_q[7]) [*3];
	endsequence
	sequence s_byp;
		(ctl_q[3] && ctl_q[4] && ctl_q[5] && ctl_q[6] && !ctl_q[7] && $stable(sp_q)) [*5];
	endsequence
	sequence s_hold;
		(ctl_q[4] && !ctl_q[5] && ctl_q[6] && !ctl_q[3] && !ctl_q[7]) [*5];
	endsequence
	property p_ack;
		s_req |=> wb_ack_o;
	endproperty
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	property p_en_off;
		!ctl_q[4] [*4] |-> ramp_out == 16'h0000;
	endproperty
	property p_slope;
		s_ramp |-> (ramp_out - $past(ramp_out)) inside {16'h0000, 16'h0001, 16'hFFFF};
	endproperty
	property p_bypass;
		s_byp |-> ramp_out == sp_q;
	endproperty
	property p_set;
		(ctl_q[7] && ctl_q[4] && !ctl_q[8] && !ctl_q[3] && $stable(setv_q)) [*4]
			|-> ramp_out == setv_q;
	endproperty
	property p_hold;
		s_hold |=> $stable(ramp_out);
	endproperty
	property p_conflict;
		(ctl_q[1] && ctl_q[2]) [*4] |-> setting_conflict_fault;
	endproperty
	a_ack: assert property (p_ack) else $error("ack missing after request");
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	a_en_off: assert property (p_en_off) else $error("output not zero while disabled");
	a_slope: assert property (p_slope) else $error("output step above one code");
	a_bypass: assert property (p_bypass) else $error("bypass output differs");
	a_set: assert property (p_set) else $error("set output differs");
	a_hold: assert property (p_hold) else $error("output moved while held");
	a_conflict: assert property (p_conflict) else $error("conflict fault missing");
endmodule // rfg_core_properties

bind rfg_core rfg_core_properties u_rfg_core_properties (
	.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ramp_out(ramp_out),
	.setting_conflict_fault(setting_conflict_fault)
);

/* File: dv/rfg_seq_model.sv */
`timescale 1ns/1ps
module rfg_seq_model (
	input  wire logic        mclk,
	input  wire logic        ack,
	output logic             cyc,
	output logic             stb,
	output logic             we,
	output logic [7:0]       adr,
	output logic [3:0]       sel,
	output logic [31:0]      dat
);
	// ----------------------------------------------------------------
	// Classic single-cycle bus master of the sequence control
	// ----------------------------------------------------------------
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		sel = 4'h0;
		dat = 32'h00000000;
	end
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
		output bit ok);
		int n;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hF;
		dat <= d;
		ok = 1'b0;
		n = 0;
		while (!ok && n < 20) begin
			@(posedge mclk);
			ok = (ack === 1'b1);
			n++;
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		// Released data never keeps its last value
		dat <= ~d;
	endtask
endmodule // rfg_seq_model

/* File: dv/rfg_core_tb_top.sv */
`timescale 1ns/1ps
module rfg_core_tb_top
	import rfg_pkg::*;
;
	// ----------------------------------------------------------------
	// Bench
	// ----------------------------------------------------------------
	localparam int          MS = 16384;
	localparam logic [31:0] W = 32'h0000FFFF;
	localparam logic [31:0] RUN = 32'h00000071;
	localparam logic [31:0] BYP = 32'h00000008;
	localparam logic [31:0] STRT = 32'h00000020;
	localparam logic [31:0] SPEN = 32'h00000040;
	typedef struct {logic [31:0] e; logic [31:0] m; int tol;} rfg_note_t;
	logic        mclk, rst_n, cyc, stb, we, ack, fault;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [31:0] dat_i, dat_o, seed;
	logic [15:0] ramp_out, v;
	rfg_note_t   notes[$];
	int          mismatches = 0;
	int          cmp_count = 0;
	rfg_core #(.CYC_PER_MS(MS)) u_rfg_core (.mclk(mclk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .ramp_out(ramp_out),
		.setting_conflict_fault(fault));
	rfg_seq_model u_rfg_seq_model (.mclk(mclk), .ack(ack), .cyc(cyc), .stb(stb),
		.we(we), .adr(adr), .sel(sel), .dat(dat_i));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task summarize;
		if (notes.size() != 0) begin
			mismatches++;
			$display("MISMATCH notes_left expected 0 seen %0d", notes.size());
		end
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		bit ok;
		u_rfg_seq_model.xfer(a, w, d, ok);
		if (!ok) begin
			mismatches++;
			$display("MISMATCH bus_ack expected 1 seen 0");
			summarize();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
		input int tol);
		notes.push_back('{e, m, tol});
		bus(a, 1'b0, 32'h00000000);
	endtask
	// Read data is taken at the ack edge and compared with the oldest note
	always @(posedge mclk) begin : mon
		rfg_note_t          n;
		logic signed [16:0] df;
		if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
			n = notes.pop_front();
			cmp_count++;
			df = $signed({dat_o[15], dat_o[15:0]}) - $signed({n.e[15], n.e[15:0]});
			if (n.tol == 0 ? ((dat_o & n.m) !== (n.e & n.m))
				: (^dat_o[15:0] === 1'bx || df > n.tol || df < -n.tol)) begin
				mismatches++;
				$display("MISMATCH read_data expected %h seen %h", n.e, dat_o);
			end
		end
	end
	initial begin
		rst_n = 1'b0;
		seed = 32'h00009C9B;
		repeat (4) @(posedge mclk);
		rst_n <= 1'b1;
		chk(RFG_CTRL_OFS, {16'h0000, RFG_CTRL_RST}, W, 0);
		chk(RFG_TIME_OFS, {16'h0000, RFG_RAMP_RST}, W, 0);
		chk(RFG_TIME_LAST, {16'h0000, RFG_ROUND_RST}, W, 0);
		chk(8'h80, 32'h00000000, 32'hFFFFFFFF, 0);
		wr(RFG_OUT_OFS, 32'h00001111);
		chk(RFG_OUT_OFS, 32'h00000000, W, 0);
		wr(RFG_TIME_OFS, 32'h00000001);
		wr(8'h24, 32'h00000002);
		wr(RFG_SP_OFS, 32'h00004000);
		wr(RFG_CTRL_OFS, 32'h00000061);
		repeat (50) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00000000, W, 0);
		wr(RFG_CTRL_OFS, RUN);
		repeat (MS / 2) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00002000, W, 16);
		wr(RFG_CTRL_OFS, RUN & ~STRT);
		repeat (200) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00002000, W, 24);
		wr(RFG_CTRL_OFS, RUN);
		repeat (MS / 2 + 100) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00004000, W, 0);
		wr(RFG_SP_OFS, 32'h00000000);
		repeat (MS / 2) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00003000, W, 16);
		wr(RFG_SP_OFS, 32'h00004000);
		wr(RFG_CTRL_OFS, (RUN & ~SPEN) | 32'h00000002);
		chk(RFG_STAT_OFS, 32'h00000000, 32'h00000018, 0);
		repeat (25000) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00000000, W, 0);
		wr(RFG_CTRL_OFS, RUN | BYP);
		for (int i = 0; i < 4; i++) begin
			seed = xs(seed);
			v = 16'(seed % 32'h00008001) - 16'h4000;
			wr(RFG_SP_OFS, {{16{v[15]}}, v});
			repeat (5) @(posedge mclk);
			chk(RFG_OUT_OFS, {16'h0000, v}, W, 0);
		end
		wr(RFG_SETV_OFS, 32'hFFFFC123);
		wr(RFG_CTRL_OFS, RUN | 32'h00000080);
		repeat (5) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h0000C123, W, 0);
		wr(RFG_CTRL_OFS, RUN | 32'h00000180);
		repeat (5) @(posedge mclk);
		chk(RFG_OUT_OFS, {16'h0000, v}, W, 0);
		wr(RFG_SETV_OFS, 32'hFFFFF000);
		wr(RFG_SP_OFS, 32'h00001000);
		wr(RFG_CTRL_OFS, RUN | 32'h00000080);
		repeat (5) @(posedge mclk);
		// Crossing zero: fall timing down to zero, rise timing beyond it
		wr(RFG_CTRL_OFS, RUN);
		repeat (10240) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00000800, W, 16);
		wr(RFG_CTRL_OFS, RUN | 32'h00000002);
		chk(RFG_STAT_OFS, 32'h00000008, 32'h00000018, 0);
		wr(RFG_CTRL_OFS, RUN | 32'h00000004);
		chk(RFG_STAT_OFS, 32'h00000010, 32'h00000018, 0);
		wr(RFG_CTRL_OFS, RUN | 32'h00000006);
		repeat (3) @(posedge mclk);
		chk(RFG_FAULT_OFS, 32'h00000001, 32'h00000001, 0);
		wr(RFG_CTRL_OFS, RUN);
		wr(RFG_FAULT_OFS, 32'h00000001);
		chk(RFG_FAULT_OFS, 32'h00000000, 32'h00000001, 0);
		wr(RFG_CTRL_OFS, 32'h00000000);
		wr(RFG_CTRL_OFS, RUN | BYP | 32'h00002200);
		repeat (10) @(posedge mclk);
		chk(RFG_STAT_OFS, 32'h0000000C, 32'h0000001C, 0);
		wr(RFG_CTRL_OFS, RUN | BYP | 32'h00002000);
		chk(RFG_STAT_OFS, 32'h00000000, 32'h0000001C, 0);
		wr(RFG_CTRL_OFS, RUN | BYP | 32'h00002204);
		chk(RFG_STAT_OFS, 32'h00000010, 32'h00000018, 0);
		wr(RFG_SP_OFS, 32'h00000800);
		wr(RFG_CTRL_OFS, 32'h00000000);
		wr(RFG_CTRL_OFS, RUN | 32'h00002200);
		chk(RFG_STAT_OFS, 32'h00000000, 32'h0000001E, 0);
		repeat (2200) @(posedge mclk);
		chk(RFG_STAT_OFS, 32'h0000000E, 32'h0000001E, 0);
		wr(RFG_CTRL_OFS, (RUN & ~32'h00000001) | 32'h00002200);
		chk(RFG_STAT_OFS, 32'h00000000, 32'h0000001E, 0);
		wr(RFG_CTRL_OFS, RUN | 32'h00002000);
		chk(RFG_STAT_OFS, 32'h00000002, 32'h0000001E, 0);
		wr(RFG_CTRL_OFS, RUN | 32'h00002200);
		chk(RFG_STAT_OFS, 32'h0000000E, 32'h0000001E, 0);
		// Initial rounding of 1 ms: half way in, a quarter of the straight distance
		wr(RFG_CTRL_OFS, 32'h00000000);
		wr(8'h28, 32'h00000001);
		wr(RFG_SP_OFS, 32'h00004000);
		wr(RFG_CTRL_OFS, RUN);
		repeat (MS / 2) @(posedge mclk);
		chk(RFG_OUT_OFS, 32'h00000800, W, 32);
		// Let the monitor take the last read before the verdict
		repeat (2) @(posedge mclk);
		summarize();
	end
endmodule // rfg_core_tb_top
